/* verilog/flash_sync_burst_config_read.sv */
`timescale 1ns/10ps
`include "flash_regs.svh"

// Functional notes
// - Powers up directly in burst read mode.
// - Captured address then auto-incrementing 16-bit stream.
// - One new word per beat clock cycle.
// - No wait states inserted during bursts.
// - Signals ready after power-on, bursts immediately.
// - Start address captured by address latch.
// - 23-bit address, random single-word read.
// - 131 blocks, 127 of them uniform 64K main blocks.
// - Four 16K parameter blocks at top.
// - Erase whole blocks, program single words.
// - 8M words of 16 bits, all addressable.
// - Data bus bidirectional for data and commands.
// - Answers common flash interface queries.
module flash_sync_burst_config_read (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [22:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic latch_en_n,
    input wire logic configuration_beat_input,
    input wire logic device_reset_input_n,
    input wire logic ready_wait_in,
    output logic ready_wait_out,
    output logic ready_wait_oe_n
);
    import flash_pkg::*;

    // Synchroniser stages and previous sample for edge detection
    pins_s pin_meta_reg;
    pins_s pin_sync_reg;
    pins_s pin_prev_reg;
    pins_s pin_now;
    // Array storage, 8M words
    logic [15:0] mem [0:`MEM_WORDS-1];
    // Control state
    state_e state_reg;
    logic [4:0] init_cnt_reg;
    logic [22:0] burst_addr_reg;
    logic [22:0] erase_addr_reg;
    logic [16:0] erase_left_reg;
    logic [15:0] data_reg;
    // Decoded events
    logic dev_rst;
    logic beat_rise;
    logic write_done;
    logic latch_now;
    logic selected;
    logic prog_fire;
    logic [15:0] query_word;

    // Group the pins so that one two-stage synchroniser handles them
    always_comb begin
        pin_now.addr = addr;
        pin_now.dq = dq_in;
        pin_now.chip_en_n = chip_en_n;
        pin_now.out_en_n = out_en_n;
        pin_now.write_en_n = write_en_n;
        pin_now.latch_en_n = latch_en_n;
        pin_now.beat = configuration_beat_input;
        pin_now.reset_n = device_reset_input_n;
    end

    // Two flip-flops before any logic looks at a pin
    always_ff @(posedge ref_clk) begin
        pin_meta_reg <= pin_now;
        pin_sync_reg <= pin_meta_reg;
    end

    // Previous synchronised sample, read only by edge detectors
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_prev_reg <= '1;
        end else begin
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Events derived from the synchronised pins
    assign dev_rst = rst | ~pin_sync_reg.reset_n;
    assign selected = ~pin_sync_reg.chip_en_n;
    assign beat_rise = pin_sync_reg.beat & ~pin_prev_reg.beat;
    assign latch_now = selected & ~pin_sync_reg.latch_en_n;
    assign write_done = selected & pin_sync_reg.write_en_n & ~pin_prev_reg.write_en_n;
    assign prog_fire = write_done & (state_reg == ST_PROG);

    // Query table, indexed by the low address bits
    always_comb begin
        case (pin_sync_reg.addr[7:0])
            8'h10: query_word = `QUERY_Q;
            8'h11: query_word = `QUERY_R;
            8'h12: query_word = `QUERY_Y;
            8'h27: query_word = `QUERY_SIZE_LOG2;
            8'h2c: query_word = `QUERY_BLOCKS;
            default: query_word = 16'h0000;
        endcase
    end

    // Power-on initialisation counter, restarts on any reset
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            init_cnt_reg <= 5'(`INIT_CYCLES);
        end else if (init_cnt_reg != 5'h0) begin
            init_cnt_reg <= init_cnt_reg - 5'h1;
        end
    end

    // Command state machine
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            state_reg <= ST_INIT;
        end else begin
            case (state_reg)
                // Leaves init straight into read mode, no command needed
                ST_INIT: begin
                    if (init_cnt_reg == 5'h0) begin
                        state_reg <= ST_READ;
                    end
                end
                // Read or query mode take commands
                ST_READ, ST_QUERY: begin
                    if (write_done) begin
                        case (pin_sync_reg.dq)
                            `CMD_PROGRAM: state_reg <= ST_PROG;
                            `CMD_ERASE_SETUP: state_reg <= ST_ERASE_SETUP;
                            `CMD_QUERY: state_reg <= ST_QUERY;
                            default: state_reg <= ST_READ;
                        endcase
                    end
                end
                // Next write carries the word to program
                ST_PROG: begin
                    if (write_done) begin
                        state_reg <= ST_READ;
                    end
                end
                // Confirm starts the erase, anything else aborts
                ST_ERASE_SETUP: begin
                    if (write_done) begin
                        if (pin_sync_reg.dq == `CMD_ERASE_CONFIRM) begin
                            state_reg <= ST_ERASE;
                        end else begin
                            state_reg <= ST_READ;
                        end
                    end
                end
                // Erase runs until the block is done
                ST_ERASE: begin
                    if (erase_left_reg == 17'h1) begin
                        state_reg <= ST_READ;
                    end
                end
                default: state_reg <= ST_INIT;
            endcase
        end
    end

    // Erase block range: parameter blocks in the top region, else main blocks
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            erase_addr_reg <= 23'h00_0000;
            erase_left_reg <= 17'h0_0000;
        end else if (write_done && state_reg == ST_ERASE_SETUP) begin
            if (pin_sync_reg.addr[22:16] == `PARAM_REGION) begin
                erase_addr_reg <= {pin_sync_reg.addr[22:14], 14'h0000};
                erase_left_reg <= 17'h0_4000;
            end else begin
                erase_addr_reg <= {pin_sync_reg.addr[22:16], 16'h0000};
                erase_left_reg <= 17'h1_0000;
            end
        end else if (state_reg == ST_ERASE) begin
            erase_addr_reg <= erase_addr_reg + 23'h1;
            erase_left_reg <= erase_left_reg - 17'h1;
        end
    end

    // Array writes: erase fills a whole block, program clears bits of one word
    always_ff @(posedge ref_clk) begin
        if (state_reg == ST_ERASE) begin
            mem[erase_addr_reg] <= `ERASED_WORD;
        end else if (prog_fire) begin
            mem[pin_sync_reg.addr] <= mem[pin_sync_reg.addr] & pin_sync_reg.dq;
        end
    end

    // Burst address counter: latch loads it, each beat while selected advances it
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            burst_addr_reg <= 23'h00_0000;
        end else if (latch_now) begin
            burst_addr_reg <= pin_sync_reg.addr + 23'h1;
        end else if (beat_rise && selected) begin
            burst_addr_reg <= burst_addr_reg + 23'h1;
        end
    end

    // Output word: latched address first, then one new word per beat
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            data_reg <= 16'h0000;
        end else if (state_reg == ST_QUERY) begin
            data_reg <= query_word;
        end else if (latch_now) begin
            data_reg <= mem[pin_sync_reg.addr];
        end else if (beat_rise && selected) begin
            data_reg <= mem[burst_addr_reg];
        end
    end

    // Drive the data bus only when selected, output-enabled and not writing
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            dq_oe_n <= 1'b1;
            dq_out <= 16'h0000;
        end else begin
            dq_oe_n <= ~(selected & ~pin_sync_reg.out_en_n & pin_sync_reg.write_en_n);
            dq_out <= data_reg;
        end
    end

    // Ready/wait: pulled low while busy, released once ready
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            ready_wait_out <= 1'b0;
            ready_wait_oe_n <= 1'b0;
        end else begin
            ready_wait_out <= 1'b0;
            ready_wait_oe_n <= (state_reg != ST_INIT) && (state_reg != ST_ERASE);
        end
    end

endmodule : flash_sync_burst_config_read

/* verilog/flash_regs.svh */
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

// Widths of the array port
`define ADDR_W 23
`define DATA_W 16
`define MEM_WORDS 8388608

// Block geometry: main blocks are 64 Kwords, parameter blocks 16 Kwords
`define MAIN_BLK_SHIFT 16
`define PARAM_BLK_SHIFT 14
`define PARAM_REGION 7'h7f

// Clock period and internal power-on initialisation time
`define CLK_PERIOD_NS 40
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Command codes taken on the data bus
`define CMD_READ_ARRAY 16'h00ff
`define CMD_PROGRAM 16'h0040
`define CMD_ERASE_SETUP 16'h0020
`define CMD_ERASE_CONFIRM 16'h00d0
`define CMD_QUERY 16'h0098

// Erased word value and query table contents
`define ERASED_WORD 16'hffff
`define QUERY_Q 16'h0051
`define QUERY_R 16'h0052
`define QUERY_Y 16'h0059
`define QUERY_SIZE_LOG2 16'h0018
`define QUERY_BLOCKS 16'h0083

`endif

/* verilog/flash_pkg.sv */
package flash_pkg;

    // Pins that arrive from the other party, sampled as one group
    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] dq;
        logic chip_en_n;
        logic out_en_n;
        logic write_en_n;
        logic latch_en_n;
        logic beat;
        logic reset_n;
    } pins_s;

    // Device operating states
    typedef enum logic [5:0] {
        ST_INIT = 6'b00_0001,
        ST_READ = 6'b00_0010,
        ST_PROG = 6'b00_0100,
        ST_ERASE_SETUP = 6'b00_1000,
        ST_ERASE = 6'b01_0000,
        ST_QUERY = 6'b10_0000
    } state_e;

endpackage : flash_pkg

/* verification/flash_checker.sv */
`timescale 1ns/10ps
module flash_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [22:0] addr,
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic latch_en_n,
    input wire logic configuration_beat_input,
    input wire logic device_reset_input_n,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic ready_wait_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Pin stays pulled low for the first 8 cycles of the 25-cycle init timer
    sequence init_hold;
        (!ready_wait_oe_n)[*8];
    endsequence
    a_reset_idle: assert property ($fell(rst) |-> !ready_wait_oe_n && dq_oe_n)
        else $error("outputs not idle after reset");
    a_init_hold: assert property ($fell(rst) |-> init_hold)
        else $error("ready too early after reset");
    a_ready_comes: assert property ($fell(rst) |-> ##[20:40] ready_wait_oe_n)
        else $error("ready missing after reset");
    a_pin_reset: assert property ((!device_reset_input_n)[*4] |=> !ready_wait_oe_n)
        else $error("ready shown during pin reset");
    a_ready_stays: assert property (
        (ready_wait_oe_n && write_en_n && device_reset_input_n)[*8] |=> ready_wait_oe_n)
        else $error("ready dropped without cause");
    a_bus_release: assert property (out_en_n[*5] |-> dq_oe_n)
        else $error("bus driven while output disabled");
    a_bus_drive: assert property (
        (!out_en_n && !chip_en_n && device_reset_input_n && ready_wait_oe_n)[*6] |-> !dq_oe_n)
        else $error("bus not driven while enabled");
    a_idle_stable: assert property (($stable(configuration_beat_input) && $stable(addr)
        && latch_en_n && write_en_n && ready_wait_oe_n
        && device_reset_input_n)[*8] |=> $stable(dq_out))
        else $error("data moved without a beat");
    a_chip_off_hold: assert property (
        (chip_en_n && ready_wait_oe_n && device_reset_input_n && $stable(addr))[*8]
        |=> $stable(dq_out))
        else $error("data moved with chip disabled");
endmodule : flash_checker

bind flash_sync_burst_config_read flash_checker flash_checker_inst (.*);

/* verification/config_port_model.sv */
`timescale 1ns/10ps
module config_port_model (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic ready,
    input wire logic [15:0] dq,
    output logic beat,
    output logic got,
    output logic [15:0] word
);
    logic [2:0] phase_reg = 3'h0;
    // Beat only runs once ready is seen; 4 ticks high, 4 low
    always_ff @(posedge ref_clk) begin
        phase_reg <= (run && ready) ? phase_reg + 3'h1 : 3'h0;
    end
    assign beat = phase_reg[2];
    // Bus word is taken just as the next beat rises
    always_ff @(posedge ref_clk) begin
        got <= run && ready && phase_reg == 3'h3;
        word <= dq;
    end
endmodule : config_port_model

/* verification/flash_sync_burst_config_read_test.sv */
`timescale 1ns/10ps
module flash_sync_burst_config_read_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic chip_en_n = 1'b1;
    logic out_en_n = 1'b1;
    logic write_en_n = 1'b1;
    logic latch_en_n = 1'b1;
    logic dev_rst_n = 1'b1;
    logic run = 1'b0;
    logic [22:0] addr = 23'h00_0000;
    logic [15:0] host_dq = 16'h0000;
    logic [15:0] dq_out, word;
    logic [15:0] exp_mem [8];
    logic dq_oe_n, rdy_out, rdy_oe_n, beat, got;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // Bus and pulled-up ready pin resolved from both parties
    wire logic [15:0] bus = dq_oe_n ? host_dq : dq_out;
    wire logic ready = rdy_oe_n ? 1'b1 : rdy_out;
    flash_sync_burst_config_read flash_sync_burst_config_read_inst (.ref_clk(ref_clk),
        .rst(rst), .addr(addr), .dq_in(bus), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .latch_en_n(latch_en_n), .configuration_beat_input(beat),
        .device_reset_input_n(dev_rst_n), .ready_wait_in(ready), .ready_wait_out(rdy_out),
        .ready_wait_oe_n(rdy_oe_n));
    config_port_model config_port_model_inst (.ref_clk(ref_clk), .run(run), .ready(ready),
        .dq(bus), .beat(beat), .got(got), .word(word));
    initial forever #20 ref_clk = ~ref_clk;
    task automatic results();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            results();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic wait_ready(input int lim);
        for (int i = 0; i < lim && ready !== 1'b1; i++) tick(1);
    endtask : wait_ready
    // Bus write; data held past the rising strobe, then line left toggled
    task automatic wr(input logic [15:0] d, input logic [22:0] a);
        addr <= a;
        host_dq <= d;
        out_en_n <= 1'b1;
        chip_en_n <= 1'b0;
        write_en_n <= 1'b0;
        tick(5);
        write_en_n <= 1'b1;
        tick(4);
        host_dq <= ~d;
        tick(1);
    endtask : wr
    task automatic latch(input logic [22:0] a);
        addr <= a;
        chip_en_n <= 1'b0;
        out_en_n <= 1'b0;
        latch_en_n <= 1'b0;
        tick(4);
        latch_en_n <= 1'b1;
        tick(7);
    endtask : latch
    task automatic next_word();
        tick(1);
        for (int i = 0; i < 20 && got !== 1'b1; i++) tick(1);
    endtask : next_word
    // Programmed words first, erased words after them
    function automatic logic [15:0] exp_word(input int i);
        return (i < 8) ? exp_mem[i] : 16'hffff;
    endfunction : exp_word
    initial begin
        int k;
        void'($urandom(74));
        tick(2);
        rst <= 1'b0;
        wait_ready(100);
        chk("ready", 16'(ready), 16'h0001);
        chk("bus off", 16'(dq_oe_n), 16'h0001);
        wr(16'h0020, 23'h7f_c000);
        wr(16'h00d0, 23'h7f_c000);
        chk("erase busy", 16'(ready), 16'h0000);
        wait_ready(20000);
        for (int i = 0; i < 8; i++) begin
            exp_mem[i] = (i == 0) ? 16'h0000 : 16'($urandom);
            wr(16'h0040, 23'h7f_c000 + 23'(i));
            wr(exp_mem[i], 23'h7f_c000 + 23'(i));
        end
        wr(16'h00ff, 23'h00_0000);
        latch(23'h7f_c000);
        chk("first", dq_out, exp_mem[0]);
        run <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            next_word();
            chk("burst", word, exp_word(i));
        end
        run <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            k = $urandom_range(7);
            latch(23'h7f_c000 + 23'(k));
            chk("random", dq_out, exp_word(k));
        end
        chip_en_n <= 1'b1;
        run <= 1'b1;
        tick(40);
        run <= 1'b0;
        chk("chip off", dq_out, exp_word(k));
        wr(16'h0098, 23'h00_0010);
        out_en_n <= 1'b0;
        tick(8);
        chk("query", dq_out, 16'h0051);
        wr(16'h00ff, 23'h00_0000);
        dev_rst_n <= 1'b0;
        tick(6);
        chk("pin reset", 16'(ready), 16'h0000);
        dev_rst_n <= 1'b1;
        wait_ready(100);
        chk("ready again", 16'(ready), 16'h0001);
        // Address held low by the board: latched single read must return word zero
        wr(16'h0040, 23'h00_0000);
        wr(16'h0000, 23'h00_0000);
        latch(23'h00_0000);
        chk("word zero", dq_out, 16'h0000);
        results();
    end
endmodule : flash_sync_burst_config_read_test
